// ### common/kme_pkg.sv
/*
 * kme_pkg: constants shared by the keypad menu and digit editor.
 * assumes a 40 MHz system clock; long counts are overridable at the top.
 */
package kme_pkg;
   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int CLK_HZ      = 40_000_000;
   localparam int HOLD_MS     = 1000;  // long hold threshold, ms
   localparam int DEB_MS      = 10;    // key debounce time, ms
   localparam int BLINK_MS    = 500;   // marker blink half period, ms
   localparam int HOLD_CYC    = (CLK_HZ / 1000) * HOLD_MS;
   localparam int DEB_CYC     = (CLK_HZ / 1000) * DEB_MS;
   localparam int BLINK_CYC   = (CLK_HZ / 1000) * BLINK_MS;

   // ------------------------------------------------------------------
   // panel geometry and editing
   // ------------------------------------------------------------------
   localparam int DISP_COLS   = 8;     // characters per line
   localparam int DISP_LINES  = 2;
   localparam int NKEY        = 4;
   localparam int KEY_LEFT    = 0;
   localparam int KEY_RIGHT   = 1;
   localparam int KEY_UP      = 2;
   localparam int KEY_DOWN    = 3;
   localparam int NDIG        = 5;     // editable decimal digits
   localparam int MAX_LEVEL   = 4;     // menu depth
   localparam logic [3:0] DIG_MAX = 4'h9;
   localparam logic [3:0] DIG_MIN = 4'h0;
   localparam logic [7:0] CH_MARK  = 8'h3E;  // '>'
   localparam logic [7:0] CH_SPACE = 8'h20;
   localparam logic [7:0] CH_MINUS = 8'h2D;

   // ------------------------------------------------------------------
   // screens
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      SCR_MENU,
      SCR_STATUS,
      SCR_VERSION
   } kme_scr_e;
endpackage

// ### design/kme_keypad_editor.sv
/*
 * kme_keypad_editor: four-key operator panel controller with menu
 * navigation and digit-by-digit parameter editing.
 * assumes raw key pins are asynchronous and active high; the menu store
 * supplies the item count and the parameter value, editability and
 * access permission of the selected entry; a display driver renders
 * the screen codes and characters given here.
 */
// Operation
// (RL1) panel has 2x8 character display and four direction keys only
// (RL2) navigation: left press moves up one menu level
// (RL3) left press at top menu shows the status screen
// (RL4) left press on status screen shows version and model
// (RL5) edit: left press moves cursor left, stops at leftmost digit
// (RL6) edit: one second left hold discards edit, leaves edit mode
// (RL7) navigation: right press descends into selected entry submenu
// (RL8) selected entry on first line with blinking marker on left
// (RL9) one second right hold enters edit if editable and permitted
// (RL10) on entering edit the cursor sits under the rightmost digit
// (RL11) edit: right press moves cursor right, stops at rightmost digit
// (RL12) edit: one second right hold commits value, leaves edit mode
// (RL13) navigation: up selects previous item, no effect on first
// (RL14) edit: up increments digit, carries left unless left is maximum
// (RL15) navigation: down selects the next item
// (RL16) a line of minus signs follows the last item of a menu
// (RL17) edit: down decrements digit, borrows left unless left is minimum
// (RL18) keys debounced; short and long never both fire for one press
// (RL19) refused edit stays in navigation with parameter unchanged
module kme_keypad_editor
   import kme_pkg::*;
#(
   parameter int HOLD_CYCLES  = HOLD_CYC,
   parameter int DEB_CYCLES   = DEB_CYC,
   parameter int BLINK_CYCLES = BLINK_CYC
) (
   input  wire logic                 sys_clk,
   input  wire logic                 srst,
   input  wire logic [NKEY-1:0]      key_pin,
   input  wire logic [3:0]           item_count,
   input  wire logic [4*NDIG-1:0]    param_value,
   input  wire logic                 param_editable,
   input  wire logic                 access_ok,
   output logic      [1:0]           screen_q,
   output logic      [1:0]           menu_level_q,
   output logic      [3:0]           menu_item_q,
   output logic      [7:0]           mark_char_q,
   output logic      [7:0]           end_char_q,
   output logic                      edit_mode_q,
   output logic      [2:0]           cursor_q,
   output logic      [4*NDIG-1:0]    edit_value_q,
   output logic                      commit_q,
   output logic                      cancel_q
);
   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // one digit step with carry or borrow into the left neighbour
   function automatic logic [4*NDIG-1:0] step_val(
      input logic [4*NDIG-1:0] v,
      input logic [2:0]        pos,
      input logic              up);
      logic [3:0] cur;
      logic [3:0] nxt;
      logic [3:0] lim;
      logic [3:0] wrap;
      step_val = v;
      cur  = v[4*pos +: 4];
      lim  = up ? DIG_MAX : DIG_MIN;
      wrap = up ? DIG_MIN : DIG_MAX;
      nxt  = 4'h0;
      if (cur != lim) begin
         step_val[4*pos +: 4] = up ? cur + 4'h1 : cur - 4'h1;
      end else if (pos < 3'(NDIG - 1)) begin
         nxt = v[4*(pos+1) +: 4];
         if (nxt != lim) begin
            step_val[4*(pos+1) +: 4] = up ? nxt + 4'h1 : nxt - 4'h1;
            step_val[4*pos +: 4] = wrap;
         end
      end
   endfunction

   // ------------------------------------------------------------------
   // key synchronisers and debounce
   // ------------------------------------------------------------------
   logic [NKEY-1:0] meta_q;
   logic [NKEY-1:0] sync_q;
   logic [NKEY-1:0] stable_q;
   logic [18:0]     deb_cnt_q [NKEY];

   // two flip-flops per key pin
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= key_pin;
         sync_q <= meta_q;
      end
   end

   // accept a new level after it holds for the debounce time
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         stable_q <= '0;
         for (int k = 0; k < NKEY; k++) deb_cnt_q[k] <= '0;
      end else begin
         for (int k = 0; k < NKEY; k++) begin
            if (sync_q[k] == stable_q[k]) begin
               deb_cnt_q[k] <= '0;
            end else if (deb_cnt_q[k] == 19'(DEB_CYCLES - 1)) begin
               deb_cnt_q[k] <= '0;
               stable_q[k]  <= sync_q[k];       // [RL18]
            end else begin
               deb_cnt_q[k] <= deb_cnt_q[k] + 19'h0_0001;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // short and long press detection
   // ------------------------------------------------------------------
   logic [NKEY-1:0] prev_q;
   logic [25:0]     hold_cnt_q [2];
   logic [1:0]      long_done_q;
   logic            sh_l, sh_r, lg_l, lg_r, pr_u, pr_d;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         prev_q      <= '0;
         long_done_q <= '0;
         for (int k = 0; k < 2; k++) hold_cnt_q[k] <= '0;
      end else begin
         prev_q <= stable_q;
         for (int k = 0; k < 2; k++) begin
            if (!stable_q[k]) begin
               hold_cnt_q[k]  <= '0;
               long_done_q[k] <= 1'b0;
            end else if (!long_done_q[k]) begin
               if (hold_cnt_q[k] == 26'(HOLD_CYCLES - 1)) begin
                  long_done_q[k] <= 1'b1;       // [RL18]
               end
               hold_cnt_q[k] <= hold_cnt_q[k] + 26'h000_0001;
            end
         end
      end
   end

   // left/right act on release unless the hold already fired
   assign sh_l = prev_q[KEY_LEFT] & ~stable_q[KEY_LEFT]
                 & ~long_done_q[KEY_LEFT];           // [RL18]
   assign sh_r = prev_q[KEY_RIGHT] & ~stable_q[KEY_RIGHT]
                 & ~long_done_q[KEY_RIGHT];
   assign lg_l = stable_q[KEY_LEFT] & ~long_done_q[KEY_LEFT]
                 & (hold_cnt_q[KEY_LEFT] == 26'(HOLD_CYCLES - 1));
   assign lg_r = stable_q[KEY_RIGHT] & ~long_done_q[KEY_RIGHT]
                 & (hold_cnt_q[KEY_RIGHT] == 26'(HOLD_CYCLES - 1));
   assign pr_u = stable_q[KEY_UP] & ~prev_q[KEY_UP];
   assign pr_d = stable_q[KEY_DOWN] & ~prev_q[KEY_DOWN];

   // ------------------------------------------------------------------
   // navigation
   // ------------------------------------------------------------------
   kme_scr_e scr_q;

   // screens, menu level and selected item; frozen during editing
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         scr_q        <= SCR_MENU;
         menu_level_q <= '0;
         menu_item_q  <= '0;
      end else if (!edit_mode_q) begin
         case (scr_q)
            SCR_MENU: begin
               if (sh_l && menu_level_q == 2'h0) begin
                  scr_q <= SCR_STATUS;                      // [RL3]
               end else if (sh_l) begin
                  menu_level_q <= menu_level_q - 2'h1;      // [RL2]
                  menu_item_q  <= '0;
               end else if (sh_r &&
                            menu_level_q != 2'(MAX_LEVEL - 1)) begin
                  menu_level_q <= menu_level_q + 2'h1;      // [RL7]
                  menu_item_q  <= '0;
               end else if (pr_u && menu_item_q != 4'h0) begin
                  menu_item_q <= menu_item_q - 4'h1;        // [RL13]
               end else if (pr_d && menu_item_q + 4'h1 < item_count) begin
                  menu_item_q <= menu_item_q + 4'h1;        // [RL15]
               end
            end
            SCR_STATUS: begin
               if (sh_l) scr_q <= SCR_VERSION;              // [RL4]
               else if (sh_r) scr_q <= SCR_MENU;
            end
            SCR_VERSION: begin
               if (sh_r) scr_q <= SCR_STATUS;
            end
            default: scr_q <= SCR_MENU;
         endcase
      end
   end

   assign screen_q = scr_q;

   // ------------------------------------------------------------------
   // edit mode, cursor and value
   // ------------------------------------------------------------------
   logic enter_ok;
   assign enter_ok = scr_q == SCR_MENU && param_editable && access_ok;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         edit_mode_q  <= 1'b0;
         cursor_q     <= '0;
         edit_value_q <= '0;
         commit_q     <= 1'b0;
         cancel_q     <= 1'b0;
      end else begin
         commit_q <= 1'b0;
         cancel_q <= 1'b0;
         if (!edit_mode_q) begin
            if (lg_r && enter_ok) begin                     // [RL9] [RL19]
               edit_mode_q  <= 1'b1;
               cursor_q     <= '0;                          // [RL10]
               edit_value_q <= param_value;
            end
         end else if (lg_l) begin
            edit_mode_q <= 1'b0;                            // [RL6]
            cancel_q    <= 1'b1;
         end else if (lg_r) begin
            edit_mode_q <= 1'b0;                            // [RL12]
            commit_q    <= 1'b1;
         end else if (sh_l && cursor_q != 3'(NDIG - 1)) begin
            cursor_q <= cursor_q + 3'h1;                    // [RL5]
         end else if (sh_r && cursor_q != 3'h0) begin
            cursor_q <= cursor_q - 3'h1;                    // [RL11]
         end else if (pr_u) begin
            edit_value_q <= step_val(edit_value_q, cursor_q, 1'b1); // [RL14]
         end else if (pr_d) begin
            edit_value_q <= step_val(edit_value_q, cursor_q, 1'b0); // [RL17]
         end
      end
   end

   // ------------------------------------------------------------------
   // display characters
   // ------------------------------------------------------------------
   logic [24:0] blink_cnt_q;
   logic        blink_q;

   // blink phase for the selection marker
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         blink_cnt_q <= '0;
         blink_q     <= 1'b1;
      end else if (blink_cnt_q == 25'(BLINK_CYCLES - 1)) begin
         blink_cnt_q <= '0;
         blink_q     <= ~blink_q;
      end else begin
         blink_cnt_q <= blink_cnt_q + 25'h000_0001;
      end
   end

   // first column of line one and fill of line two
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         mark_char_q <= CH_SPACE;
         end_char_q  <= CH_SPACE;
      end else begin
         mark_char_q <= (scr_q == SCR_MENU && blink_q)
                        ? CH_MARK : CH_SPACE;               // [RL8] [RL1]
         end_char_q  <= (scr_q == SCR_MENU &&
                         menu_item_q + 4'h1 >= item_count)
                        ? CH_MINUS : CH_SPACE;              // [RL16]
      end
   end

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   property p_enter;
      !edit_mode_q && lg_r && enter_ok |=> edit_mode_q && cursor_q == 3'h0;
   endproperty
   a_enter: assert property (p_enter) // [RL9] [RL10]
      else $error("edit entry failed");

   property p_refuse;
      !edit_mode_q && lg_r && !enter_ok |=> !edit_mode_q && !commit_q;
   endproperty
   a_refuse: assert property (p_refuse) // [RL19]
      else $error("refused edit entered");

   property p_cancel;
      edit_mode_q && lg_l |=> !edit_mode_q && cancel_q ##1 !cancel_q;
   endproperty
   a_cancel: assert property (p_cancel) // [RL6]
      else $error("cancel failed");

   property p_commit;
      edit_mode_q && !lg_l && lg_r |=> !edit_mode_q && commit_q
         && edit_value_q == $past(edit_value_q);
   endproperty
   a_commit: assert property (p_commit) // [RL12]
      else $error("commit failed");

   property p_cur_left;
      edit_mode_q && sh_l && cursor_q == 3'(NDIG - 1)
         |=> cursor_q == 3'(NDIG - 1);
   endproperty
   a_cur_left: assert property (p_cur_left) // [RL5]
      else $error("cursor left edge");

   property p_cur_right;
      edit_mode_q && !lg_l && !lg_r && sh_r && cursor_q != 3'h0
         |=> cursor_q == $past(cursor_q) - 3'h1;
   endproperty
   a_cur_right: assert property (p_cur_right) // [RL11]
      else $error("cursor right move");

   property p_status;
      !edit_mode_q && scr_q == SCR_MENU && menu_level_q == 2'h0 && sh_l
         |=> scr_q == SCR_STATUS;
   endproperty
   a_status: assert property (p_status) // [RL3]
      else $error("status screen missed");

   property p_up_first;
      !edit_mode_q && scr_q == SCR_MENU && menu_item_q == 4'h0 && pr_u
         && !sh_l && !sh_r |=> menu_item_q == 4'h0;
   endproperty
   a_up_first: assert property (p_up_first) // [RL13]
      else $error("up past first item");

   property p_no_both;
      lg_l |-> !sh_l ##1 !sh_l;
   endproperty
   a_no_both: assert property (p_no_both) // [RL18]
      else $error("short and long fired");

   c_enter:  cover property (!edit_mode_q ##1 edit_mode_q);
   c_commit: cover property (commit_q);
   c_carry:  cover property (edit_mode_q && pr_u
                && edit_value_q[4*cursor_q +: 4] == DIG_MAX);
   c_version: cover property (scr_q == SCR_VERSION);
endmodule

// ### test/kme_keypad_model.sv
/*
 * kme_keypad_model: behavioural four-key pad with contact bounce.
 * assumes the bench supplies sys_clk and calls press() from its sequence.
 */
module kme_keypad_model
   import kme_pkg::*;
(
   input  wire logic            sys_clk,
   output logic      [NKEY-1:0] key_pin
);
   timeunit 1ns;
   timeprecision 100ps;

   // ------------------------------------------------------------------
   // key actuation
   // ------------------------------------------------------------------
   // all keys released at power up; four keys are the only inputs
   initial key_pin = '0;

   // one press: one-cycle bounces around a steady hold
   task automatic press(input int key, input int hold);
      for (int i = 0; i < 3; i++) begin
         @(posedge sys_clk);
         key_pin[key] <= ~i[0];
      end
      repeat (hold) @(posedge sys_clk);
      for (int i = 0; i < 3; i++) begin
         key_pin[key] <= i[0];
         @(posedge sys_clk);
      end
   endtask
endmodule

// ### test/tb_top.sv
/*
 * tb_top: self-checking bench for the keypad menu and digit editor.
 * assumes short counts for hold, debounce and blink; state changes are
 * checked in order against a queue of expected states.
 */
module tb_top
   import kme_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   localparam int HOLD  = 40;
   localparam int SHORT = 12;
   localparam int LONG  = 60;
   typedef struct packed {
      logic [1:0]        scr;
      logic [1:0]        lvl;
      logic [3:0]        item;
      logic              edit;
      logic [2:0]        cur;
      logic [4*NDIG-1:0] val;
      logic              cmt;
      logic              cnc;
   } kme_exp_s;
   logic              sys_clk = 1'b0;
   logic              srst;
   logic [NKEY-1:0]   key_pin;
   logic [3:0]        item_count;
   logic [4*NDIG-1:0] param_value;
   logic              param_editable;
   logic              access_ok;
   logic [1:0]        screen_q;
   logic [1:0]        menu_level_q;
   logic [3:0]        menu_item_q;
   logic [7:0]        mark_char_q;
   logic [7:0]        end_char_q;
   logic              edit_mode_q;
   logic [2:0]        cursor_q;
   logic [4*NDIG-1:0] edit_value_q;
   logic              commit_q;
   logic              cancel_q;
   kme_exp_s          st;
   kme_exp_s          last_st;
   kme_exp_s          got;
   kme_exp_s          prev_got;
   kme_exp_s          exp_q[$];
   int                num_errors = 0;
   int                n_checks = 0;
   int                cycles = 0;
   logic [31:0]       rnd = 32'h0000_713a;
   logic [7:0]        on_seen;
   logic [7:0]        off_seen;
   logic [4*NDIG-1:0] v;

   kme_keypad_editor #(.HOLD_CYCLES(HOLD), .DEB_CYCLES(4),
                       .BLINK_CYCLES(16)) uut (
      .sys_clk(sys_clk), .srst(srst), .key_pin(key_pin),
      .item_count(item_count), .param_value(param_value),
      .param_editable(param_editable), .access_ok(access_ok),
      .screen_q(screen_q), .menu_level_q(menu_level_q),
      .menu_item_q(menu_item_q), .mark_char_q(mark_char_q),
      .end_char_q(end_char_q), .edit_mode_q(edit_mode_q),
      .cursor_q(cursor_q), .edit_value_q(edit_value_q),
      .commit_q(commit_q), .cancel_q(cancel_q));
   kme_keypad_model pad (.sys_clk(sys_clk), .key_pin(key_pin));

   // 40 MHz clock
   always #12.5 sys_clk = ~sys_clk;

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   function automatic logic [4*NDIG-1:0] rand_bcd();
      logic [4*NDIG-1:0] r;
      for (int i = 0; i < NDIG; i++) begin
         rnd ^= rnd << 13;
         rnd ^= rnd >> 17;
         rnd ^= rnd << 5;
         r[4*i +: 4] = 4'(rnd % 10);
      end
      return r;
   endfunction

   // one digit step with carry or borrow into the left neighbour
   function automatic logic [4*NDIG-1:0] bcd_step(
         input logic [4*NDIG-1:0] x, input int p, input bit up);
      logic [3:0] lim;
      lim = up ? DIG_MAX : DIG_MIN;
      if (x[4*p +: 4] != lim) begin
         x[4*p +: 4] = up ? x[4*p +: 4] + 4'h1 : x[4*p +: 4] - 4'h1;
      end else if (p < NDIG - 1 && x[4*p+4 +: 4] != lim) begin
         x[4*p+4 +: 4] = up ? x[4*p+4 +: 4] + 4'h1 : x[4*p+4 +: 4] - 4'h1;
         x[4*p +: 4] = up ? DIG_MIN : DIG_MAX;
      end
      return x;
   endfunction

   // note the model state if it changed; pulses last one note only
   task automatic expect_now();
      if (st !== last_st) exp_q.push_back(st);
      st.cmt = 1'b0;
      st.cnc = 1'b0;
      last_st = st;
   endtask

   task automatic key(input int k, input int hold);
      pad.press(k, hold);
      repeat (16) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   task automatic set_param(input logic [4*NDIG-1:0] x, input logic ed,
                            input logic ok);
      @(posedge sys_clk);
      param_value    <= x;
      param_editable <= ed;
      access_ok      <= ok;
   endtask

   task automatic check_state(input kme_exp_s e, input kme_exp_s g);
      n_checks++;
      if (!e.edit) begin
         e.cur = '0;
         g.cur = '0;
      end
      if (!(e.edit || e.cmt)) begin
         e.val = '0;
         g.val = '0;
      end
      if (g !== e) begin
         num_errors++;
         $display("mismatch at %0t: state %h expected %h", $time, g, e);
      end
   endtask

   task automatic check_val(input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch at %0t: char %h expected %h", $time, g, e);
      end
   endtask

   task automatic end_of_test();
      num_errors += exp_q.size();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------------
   // watcher and timeout
   // ------------------------------------------------------------------
   // each visible state change or pulse consumes the oldest note
   always @(negedge sys_clk) begin
      got = {screen_q, menu_level_q, menu_item_q, edit_mode_q, cursor_q,
             edit_value_q, commit_q, cancel_q};
      if (!srst && (got[33:25] !== prev_got[33:25] || got.cmt || got.cnc
                    || (got.edit && got[24:2] !== prev_got[24:2]))) begin
         if (exp_q.size() == 0) begin
            num_errors++;
            $display("mismatch at %0t: unexpected change %h", $time, got);
         end else begin
            check_state(exp_q.pop_front(), got);
         end
      end
      prev_got = got;
   end

   // cut a hang short
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 6000) begin
         num_errors++;
         $display("mismatch at %0t: timeout", $time);
         end_of_test();
      end
   end

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      srst = 1'b1;
      item_count = 4'h3;
      param_value = '0;
      param_editable = 1'b0;
      access_ok = 1'b0;
      st = '0;
      last_st = '0;
      repeat (6) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      // menu walk down to the end line and up past the first item
      for (int i = 1; i < 4; i++) begin
         if (i < 3) st.item = 4'(i);
         expect_now();
         key(KEY_DOWN, SHORT);
      end
      check_val(CH_MINUS, end_char_q);
      for (int i = 0; i < 3; i++) begin
         if (st.item != 0) st.item--;
         expect_now();
         key(KEY_UP, SHORT);
      end
      check_val(CH_SPACE, end_char_q);
      on_seen = CH_SPACE;
      off_seen = CH_MARK;
      repeat (40) begin
         @(negedge sys_clk);
         if (mark_char_q === CH_MARK) on_seen = CH_MARK;
         if (mark_char_q === CH_SPACE) off_seen = CH_SPACE;
      end
      check_val(CH_MARK, on_seen);
      check_val(CH_SPACE, off_seen);
      $display("test menu walk done");
      // levels and screens
      st.lvl = 1;
      expect_now();
      key(KEY_RIGHT, SHORT);
      st.item = 1;
      expect_now();
      key(KEY_DOWN, SHORT);
      st.lvl = 0;
      st.item = 0;
      expect_now();
      key(KEY_LEFT, SHORT);
      for (int s = 1; s < 3; s++) begin
         st.scr = 2'(s);
         expect_now();
         key(KEY_LEFT, SHORT);
      end
      check_val(CH_SPACE, mark_char_q);
      key(KEY_UP, SHORT);
      for (int s = 1; s >= 0; s--) begin
         st.scr = 2'(s);
         expect_now();
         key(KEY_RIGHT, SHORT);
      end
      $display("test screens done");
      // refused edit requests
      set_param(rand_bcd(), 1'b0, 1'b1);
      key(KEY_RIGHT, LONG);
      set_param(rand_bcd(), 1'b1, 1'b0);
      key(KEY_RIGHT, LONG);
      $display("test refusal done");
      // edit with carry, borrow, cursor limits and commit
      v = rand_bcd();
      v[7:0] = 8'h09;
      set_param(v, 1'b1, 1'b1);
      st.edit = 1'b1;
      st.cur = 0;
      st.val = v;
      expect_now();
      key(KEY_RIGHT, LONG);
      st.val = bcd_step(st.val, 0, 1'b1);
      expect_now();
      key(KEY_UP, SHORT);
      for (int i = 0; i < 2; i++) begin
         st.val = bcd_step(st.val, 0, 1'b0);
         expect_now();
         key(KEY_DOWN, SHORT);
      end
      key(KEY_RIGHT, SHORT);
      for (int i = 1; i <= NDIG; i++) begin
         if (i < NDIG) st.cur = 3'(i);
         expect_now();
         key(KEY_LEFT, SHORT);
      end
      st.val = bcd_step(st.val, NDIG - 1, 1'b1);
      expect_now();
      key(KEY_UP, SHORT);
      st.cur = 3'(NDIG - 2);
      expect_now();
      key(KEY_RIGHT, SHORT);
      st.edit = 1'b0;
      st.cmt = 1'b1;
      expect_now();
      key(KEY_RIGHT, LONG);
      $display("test edit commit done");
      // edit then cancel by a long left hold
      v = rand_bcd();
      set_param(v, 1'b1, 1'b1);
      st.edit = 1'b1;
      st.cur = 0;
      st.val = v;
      expect_now();
      key(KEY_RIGHT, LONG);
      st.val = bcd_step(st.val, 0, 1'b0);
      expect_now();
      key(KEY_DOWN, SHORT);
      st.edit = 1'b0;
      st.cnc = 1'b1;
      expect_now();
      key(KEY_LEFT, LONG);
      $display("test edit cancel done");
      end_of_test();
   end
endmodule
